// File: wdcs_pkg.sv
// Purpose: Shared constants for the watchdog control and status block
// Assumes: 32-bit AXI4-Lite register bus, one word per register
// Notes:   Offsets are byte addresses
package wdcs_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [11:0] WDCS_OFF_CTRL  = 12'h0D8;
    localparam logic [11:0] WDCS_OFF_IEN   = 12'h0E8;
    localparam logic [11:0] WDCS_OFF_IPRI  = 12'h0F8;
    localparam logic [11:0] WDCS_OFF_IDLE  = 12'h100;
    localparam logic [11:0] WDCS_OFF_ISTAT = 12'h104;
    localparam logic [11:0] WDCS_OFF_IMASK = 12'h108;

    // ****************************************
    // Control register fields and reset values
    // ****************************************
    localparam int BIT_POR   = 6;
    localparam int BIT_CSEL  = 4;
    localparam int BIT_IFLAG = 3;
    localparam int BIT_RFLAG = 2;
    localparam int BIT_REN   = 1;
    localparam int BIT_RSTRT = 0;
    localparam int BIT_IEN   = 5;
    localparam int BIT_IPRI  = 5;
    localparam int BIT_IRCW  = 5;
    localparam logic [7:0] WDCS_CTRL_RST = 8'h40;
    localparam logic [7:0] WDCS_REG_RST  = 8'h00;
    localparam logic [7:0] WDCS_CTRL_RW  = 8'h5F;  // Implemented bits
    // Bits that keep their value on an external reset
    localparam logic [7:0] WDCS_EXT_KEEP = 8'h46;

    // ****************************************
    // Timing
    // ****************************************
    localparam int WDCS_WDT_LEN       = 16;  // Counter width
    localparam int WDCS_RST_DLY_TICKS = 512; // Time-out to reset delay

    // Bus responses
    localparam logic [1:0] WDCS_RESP_OK  = 2'h0;
    localparam logic [1:0] WDCS_RESP_ERR = 2'h2;

    typedef enum logic [1:0] {
        WDCS_RUN  = 2'b00,
        WDCS_WAIT = 2'b01,
        WDCS_HOLD = 2'b10
    } wdcs_state_type;
endpackage : wdcs_pkg

// File: wdcs_counter.sv
// Purpose: Watchdog counter with time-out and delayed reset request
// Assumes: Tick inputs are one-cycle enables on clk
// Notes:   Counter width is a parameter
`timescale 1ns/1ps
`default_nettype none
module wdcs_counter
    import wdcs_pkg::*;
#(
    parameter int LEN = WDCS_WDT_LEN
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic tick,
    input  wire logic restart,
    input  wire logic reset_enable,
    // Events
    output logic      timeout,
    output logic      wd_reset
);
    wdcs_state_type   state_r;
    wdcs_state_type   state_nxt;
    logic [LEN-1:0]   cnt_r;
    logic [9:0]       dly_r;
    logic             at_top;
    logic             dly_done;

    // Decode of counter ends
    assign at_top   = (cnt_r == {LEN{1'b1}});
    assign dly_done = (dly_r == 10'(WDCS_RST_DLY_TICKS - 1));

    // Next state: restart pre-empts both time-out and reset
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            WDCS_RUN: begin
                if (!restart && tick && at_top) state_nxt = WDCS_WAIT;
            end
            WDCS_WAIT: begin
                if (restart) state_nxt = WDCS_RUN;
                else if (tick && dly_done) state_nxt = WDCS_HOLD;
            end
            WDCS_HOLD: state_nxt = WDCS_RUN;
            default:   state_nxt = WDCS_RUN;
        endcase
    end

    // Counter and delay advance only on the chosen tick
    always_ff @(posedge clk) begin
        if (rst || restart || state_r == WDCS_HOLD) begin
            cnt_r <= '0;
            dly_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
            if (state_r == WDCS_WAIT) dly_r <= dly_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) state_r <= WDCS_RUN;
        else     state_r <= state_nxt;
    end

    // Time-out pulse, then reset only when enabled at the end of the delay
    assign timeout  = (state_r == WDCS_RUN) && (state_nxt == WDCS_WAIT);
    assign wd_reset = (state_r == WDCS_HOLD) && reset_enable;
endmodule : wdcs_counter
`default_nettype wire

// File: wdcs_top.sv
// Purpose: Watchdog control/status registers, interrupt and reset logic
// Assumes: Reset inputs are synchronous one-cycle pulses; rst is power-on
// Notes:   Oscillator clocks arrive as tick enables on clk
// How it works
// - Power-on sets the power-on flag; only software clears it.
// - Clock-select 1 uses sub-oscillator ticks, 0 uses main oscillator ticks.
// - Every counter time-out sets the interrupt flag.
// - Interrupt flag clears only by software write or any reset.
// - Interrupt request needs flag, enable bit 5, global enable, other conditions.
// - Watchdog reset sets the reset flag; it stays until software or a power-on or power-fail reset clears it.
// - Power-fail reset clears the reset flag.
// - With reset enable 0 the watchdog never changes the reset flag.
// - Reset enable 1 enables watchdog reset; 0 means time-outs never reset.
// - Writing restart 1 restarts counter; restart bit clears itself.
// - Unrestarted time-out with reset enable gives reset 512 counter ticks later.
// - Reset flag: 1 on watchdog reset, 0 on power resets, kept on external.
// - Only power-on reset or a software write clears the reset enable bit.
// - External reset loads control pattern 0x000xx0b, x bits kept.
// - Priority bit 1 means high priority, 0 low priority.
// - Watchdog wake from idle sets the idle-release record bit.
`timescale 1ns/1ps
`default_nettype none
module wdcs_top
    import wdcs_pkg::*;
#(
    parameter int WDT_LEN = WDCS_WDT_LEN
) (
    // Clock and power-on reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Other reset sources, one-cycle pulses
    input  wire logic        ext_rst,
    input  wire logic        power_fail_rst,
    // Counter clock ticks
    input  wire logic        main_oscillator_clock,
    input  wire logic        sub_oscillator_clock,
    // Interrupt context
    input  wire logic        global_irq_enable,
    input  wire logic        other_irq_ok,
    input  wire logic        idle_mode,
    // Watchdog outputs
    output logic             watchdog_reset_out,
    output logic             watchdog_irq_req,
    output logic             watchdog_irq_high,
    output logic             irq,
    // AXI4-Lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [7:0]  ien_r;
    logic [7:0]  ipri_r;
    logic [7:0]  idle_r;
    logic [1:0]  istat_r;
    logic [1:0]  imask_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [1:0]  rresp_r;
    logic [31:0] rdata_r;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_lane0;
    logic        wr_ctrl;
    logic        wr_ien;
    logic        wr_ipri;
    logic        wr_idle;
    logic        wr_istat;
    logic        wr_imask;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  wbyte;
    logic [7:0]  rd_val;
    logic        tick;
    logic        timeout;
    logic        wd_reset;
    logic        any_rst;
    logic        restart;
    logic        wake_wd;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == WDCS_OFF_CTRL) || (a == WDCS_OFF_IEN)
              || (a == WDCS_OFF_IPRI) || (a == WDCS_OFF_IDLE)
              || (a == WDCS_OFF_ISTAT) || (a == WDCS_OFF_IMASK);
    endfunction : mapped

    // ****************************************
    // Bus decode
    // ****************************************
    // Address and data taken together; one write outstanding at a time
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !rvalid_r;
    assign wr_fire  = s_axi_awready;
    assign rd_fire  = s_axi_arvalid && s_axi_arready;
    assign wr_lane0 = wr_fire && s_axi_wstrb[0];
    assign wbyte    = s_axi_wdata[7:0];
    assign wr_hit   = mapped(s_axi_awaddr);
    assign rd_hit   = mapped(s_axi_araddr);
    assign wr_ctrl  = wr_lane0 && (s_axi_awaddr == WDCS_OFF_CTRL);
    assign wr_ien   = wr_lane0 && (s_axi_awaddr == WDCS_OFF_IEN);
    assign wr_ipri  = wr_lane0 && (s_axi_awaddr == WDCS_OFF_IPRI);
    assign wr_idle  = wr_lane0 && (s_axi_awaddr == WDCS_OFF_IDLE);
    assign wr_istat = wr_lane0 && (s_axi_awaddr == WDCS_OFF_ISTAT);
    assign wr_imask = wr_lane0 && (s_axi_awaddr == WDCS_OFF_IMASK);

    // Read mux, unmapped reads zero
    assign rd_val = (s_axi_araddr == WDCS_OFF_CTRL)  ? ctrl_r :
                    (s_axi_araddr == WDCS_OFF_IEN)   ? ien_r :
                    (s_axi_araddr == WDCS_OFF_IPRI)  ? ipri_r :
                    (s_axi_araddr == WDCS_OFF_IDLE)  ? idle_r :
                    (s_axi_araddr == WDCS_OFF_ISTAT) ? {6'h00, istat_r} :
                    (s_axi_araddr == WDCS_OFF_IMASK) ? {6'h00, imask_r} : 8'h00;

    // ****************************************
    // Watchdog counter
    // ****************************************
    assign tick = ctrl_r[BIT_CSEL] ? sub_oscillator_clock
                                   : main_oscillator_clock;
    // Own reset restarts the count too, so a held reset cannot repeat at once
    assign restart = ctrl_r[BIT_RSTRT] || ext_rst || power_fail_rst
                  || wd_reset;
    assign any_rst = ext_rst || power_fail_rst || wd_reset;

    wdcs_counter #(
        .LEN (WDT_LEN)
    ) u_counter (
        .clk          (clk),
        .rst          (rst),
        .tick         (tick),
        .restart      (restart),
        .reset_enable (ctrl_r[BIT_REN]),
        .timeout      (timeout),
        .wd_reset     (wd_reset)
    );

    // ****************************************
    // Control register next value
    // ****************************************
    // Software write, then events on top so a set beats a clear
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) ctrl_nxt = wbyte & WDCS_CTRL_RW;
        ctrl_nxt[BIT_RSTRT] = wr_ctrl && wbyte[BIT_RSTRT];
        if (timeout) ctrl_nxt[BIT_IFLAG] = 1'b1;
        if (ext_rst) begin
            // Only power-on flag, reset flag and reset enable survive
            ctrl_nxt = ctrl_r & WDCS_EXT_KEEP;
        end
        if (power_fail_rst) begin
            ctrl_nxt = ctrl_r & (8'h01 << BIT_REN);
            ctrl_nxt[BIT_POR] = ctrl_r[BIT_POR];
        end
        if (wd_reset) begin
            ctrl_nxt = ctrl_r & ((8'h01 << BIT_REN) | (8'h01 << BIT_POR));
            ctrl_nxt[BIT_RFLAG] = 1'b1;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    // Power-on: POR set, reset enable and reset flag cleared
    always_ff @(posedge clk) begin
        if (rst) ctrl_r <= WDCS_CTRL_RST;
        else     ctrl_r <= ctrl_nxt;
    end

    // Enable and priority clear on every reset type
    always_ff @(posedge clk) begin
        if (rst || any_rst) begin
            ien_r  <= WDCS_REG_RST;
            ipri_r <= WDCS_REG_RST;
        end else begin
            if (wr_ien)  ien_r  <= wbyte;
            if (wr_ipri) ipri_r <= wbyte;
        end
    end

    // Idle-release record: software writable, wake sets it
    assign wake_wd = idle_mode && watchdog_irq_req;
    always_ff @(posedge clk) begin
        if (rst || any_rst) idle_r <= WDCS_REG_RST;
        else begin
            if (wr_idle) idle_r <= wbyte;
            if (wake_wd) idle_r[BIT_IRCW] <= 1'b1;
        end
    end

    // Sticky status: bit0 time-out, bit1 watchdog reset; set beats W1C
    always_ff @(posedge clk) begin
        if (rst) begin
            istat_r <= 2'h0;
            imask_r <= 2'h0;
        end else begin
            istat_r <= (istat_r & ~(wr_istat ? wbyte[1:0] : 2'h0))
                     | {wd_reset, timeout};
            if (wr_imask) imask_r <= wbyte[1:0];
        end
    end

    // ****************************************
    // Bus responses
    // ****************************************
    // Held until the master takes them
    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= WDCS_RESP_OK;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? WDCS_RESP_OK : WDCS_RESP_ERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rresp_r  <= WDCS_RESP_OK;
            rdata_r  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_hit ? WDCS_RESP_OK : WDCS_RESP_ERR;
            rdata_r  <= {24'h00_0000, rd_val};
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp  = rresp_r;
    assign s_axi_rdata  = rdata_r;
    assign watchdog_reset_out = wd_reset;
    assign watchdog_irq_req   = ctrl_r[BIT_IFLAG] && ien_r[BIT_IEN]
                             && global_irq_enable && other_irq_ok;
    assign watchdog_irq_high  = ipri_r[BIT_IPRI];
    assign irq = |(istat_r & imask_r);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_timeout_sets_flag: assert property (
        timeout && !any_rst |=> ctrl_r[BIT_IFLAG])
        else $error("time-out did not set interrupt flag");
    a_flag_holds: assert property (
        ctrl_r[BIT_IFLAG] && !wr_ctrl && !any_rst |=> ctrl_r[BIT_IFLAG])
        else $error("interrupt flag cleared without cause");
    a_por_sticky: assert property (
        ctrl_r[BIT_POR] && !wr_ctrl |=> ctrl_r[BIT_POR])
        else $error("power-on flag cleared by hardware");
    a_wdreset_flag: assert property (
        wd_reset && !power_fail_rst && !ext_rst |=> ctrl_r[BIT_RFLAG])
        else $error("watchdog reset did not set reset flag");
    a_no_reset_off: assert property (
        !ctrl_r[BIT_REN] |-> !watchdog_reset_out)
        else $error("reset while reset enable off");
    a_reset_delay: assert property (
        watchdog_reset_out |-> $past(u_counter.state_r) == WDCS_WAIT)
        else $error("reset not preceded by delay");
    a_pf_clears: assert property (
        power_fail_rst && !wd_reset |=> !ctrl_r[BIT_RFLAG])
        else $error("power-fail reset left reset flag set");
    a_enable_keeps: assert property (
        (ext_rst || power_fail_rst) && !wr_ctrl
        |=> ctrl_r[BIT_REN] == $past(ctrl_r[BIT_REN]))
        else $error("reset enable changed by non-power-on reset");
    a_ext_pattern: assert property (
        ext_rst |=> (ctrl_r & ~WDCS_EXT_KEEP) == 8'h00)
        else $error("external reset pattern wrong");
    a_restart_self: assert property (
        ctrl_r[BIT_RSTRT] && !wr_ctrl |=> !ctrl_r[BIT_RSTRT])
        else $error("restart bit did not clear");
    a_irq_request: assert property (
        watchdog_irq_req |-> ctrl_r[BIT_IFLAG] && ien_r[BIT_IEN])
        else $error("interrupt request without flag and enable");

    c_timeout:  cover property (timeout);
    c_wd_reset: cover property (watchdog_reset_out);
    c_wake:     cover property (wake_wd);
    c_restart:  cover property (u_counter.state_r == WDCS_WAIT && restart);
endmodule : wdcs_top
`default_nettype wire

// File: tb_top.sv
// Purpose: Self-checking bench for the watchdog control and status block
// Assumes: Counter shortened to 4 bits; ticks are single-cycle enables
// Notes:   Every bus wait is bounded; a hang ends the run as a failure
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import wdcs_pkg::*;
;
    localparam int LEN  = 4;
    localparam int WRAP = 1 << LEN;  // Ticks up to the first time-out
    localparam int DLY  = WDCS_RST_DLY_TICKS;  // Time-out to reset, in ticks

    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic        clk = 1'b0, rst = 1'b1, ext_rst = 1'b0, power_fail_rst = 1'b0;
    logic        main_oscillator_clock = 1'b0, sub_oscillator_clock = 1'b0;
    logic        global_irq_enable = 1'b0, other_irq_ok = 1'b0, idle_mode = 1'b0;
    logic        watchdog_reset_out, watchdog_irq_req, watchdog_irq_high, irq;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          bad_count = 0;
    int          comparisons = 0;
    int          pulses = 0;

    wdcs_top #(.WDT_LEN(LEN)) dut (
        .clk, .rst, .ext_rst, .power_fail_rst, .main_oscillator_clock,
        .sub_oscillator_clock, .global_irq_enable, .other_irq_ok, .idle_mode,
        .watchdog_reset_out, .watchdog_irq_req, .watchdog_irq_high, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    // 200 MHz clock
    always #2.5 clk = ~clk;

    // Count reset requests; a missed or doubled pulse shows in the total
    always @(posedge clk) begin
        if (watchdog_reset_out === 1'b1) pulses++;
    end

    // ****************************************
    // Reporting
    // ****************************************
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %08h seen %08h", what, exp, seen);
        end
    endtask : check

    task automatic hang();
        bad_count++;
        $display("BAD handshake expected answer seen none");
        close_out();
    endtask : hang

    // ****************************************
    // Bus tasks
    // ****************************************
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while ((s_axi_awready && s_axi_wready) !== 1'b1 && n < 64);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        while (s_axi_bvalid !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        s_axi_bready <= 1'b0;
        if (n >= 64) hang();
        check("bresp", {30'h0, s_axi_bresp}, {30'h0, exp});
    endtask : wr

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp,
                      input logic [1:0] rexp);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 64);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        s_axi_rready <= 1'b0;
        if (n >= 64) hang();
        check(what, s_axi_rdata, exp);
        check("rresp", {30'h0, s_axi_rresp}, {30'h0, rexp});
    endtask : rd

    // Ticks spaced one idle cycle apart, then let flags land
    task automatic tick(input logic sub, input int n);
        repeat (n) begin
            @(posedge clk);
            main_oscillator_clock <= !sub;
            sub_oscillator_clock  <= sub;
            @(posedge clk);
            main_oscillator_clock <= 1'b0;
            sub_oscillator_clock  <= 1'b0;
        end
        repeat (3) @(posedge clk);
    endtask : tick

    // One-cycle pulse: 0 external, 1 power-fail, 2 power-on held two cycles
    task automatic pulse_reset(input int kind);
        @(posedge clk);
        ext_rst        <= (kind == 0);
        power_fail_rst <= (kind == 1);
        rst            <= (kind == 2);
        repeat (kind == 2 ? 2 : 1) @(posedge clk);
        ext_rst        <= 1'b0;
        power_fail_rst <= 1'b0;
        rst            <= 1'b0;
        @(posedge clk);
    endtask : pulse_reset

    task automatic settle();
        @(posedge clk);
    endtask : settle

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values();
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0040, WDCS_RESP_OK);
        rd("ien", WDCS_OFF_IEN, 32'h0000_0000, WDCS_RESP_OK);
        rd("ipri", WDCS_OFF_IPRI, 32'h0000_0000, WDCS_RESP_OK);
        // Lane 0 strobe off: write answered but ignored
        s_axi_wstrb <= 4'h0;
        wr(WDCS_OFF_IPRI, 32'h0000_0020, WDCS_RESP_OK);
        s_axi_wstrb <= 4'hF;
        rd("ipri", WDCS_OFF_IPRI, 32'h0000_0000, WDCS_RESP_OK);
        rd("hole", 12'h0FC, 32'h0000_0000, WDCS_RESP_ERR);
        wr(12'h0FC, 32'h0000_00FF, WDCS_RESP_ERR);
        $display("test reset_values done");
    endtask : t_reset_values

    task automatic t_priority();
        wr(WDCS_OFF_IPRI, 32'h0000_0020, WDCS_RESP_OK);
        check("irq_high", watchdog_irq_high, 1'b1);
        wr(WDCS_OFF_IPRI, 32'h0000_0000, WDCS_RESP_OK);
        check("irq_high", watchdog_irq_high, 1'b0);
        $display("test priority done");
    endtask : t_priority

    task automatic t_timeout_irq();
        wr(WDCS_OFF_IEN, 32'h0000_0020, WDCS_RESP_OK);
        global_irq_enable <= 1'b1;
        other_irq_ok      <= 1'b1;
        tick(1'b0, WRAP - 1);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0040, WDCS_RESP_OK);
        tick(1'b0, 1);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0048, WDCS_RESP_OK);
        rd("istat", WDCS_OFF_ISTAT, 32'h0000_0001, WDCS_RESP_OK);
        settle();
        check("irq_req", watchdog_irq_req, 1'b1);
        check("irq masked", irq, 1'b0);
        idle_mode <= 1'b1;
        settle();
        idle_mode <= 1'b0;
        rd("idle", WDCS_OFF_IDLE, 32'h0000_0020, WDCS_RESP_OK);
        global_irq_enable <= 1'b0;
        settle();
        check("irq_req", watchdog_irq_req, 1'b0);
        wr(WDCS_OFF_IMASK, 32'h0000_0001, WDCS_RESP_OK);
        check("irq", irq, 1'b1);
        wr(WDCS_OFF_ISTAT, 32'h0000_0001, WDCS_RESP_OK);
        check("irq", irq, 1'b0);
        // Reset disabled: the full delay passes with no effect
        tick(1'b0, DLY + 1);
        check("pulses", pulses, 0);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0048, WDCS_RESP_OK);
        pulse_reset(0);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0040, WDCS_RESP_OK);
        $display("test timeout_irq done");
    endtask : t_timeout_irq

    task automatic t_watchdog_reset();
        wr(WDCS_OFF_CTRL, 32'h0000_0042, WDCS_RESP_OK);
        tick(1'b0, WRAP + DLY - 1);
        check("pulses", pulses, 0);
        tick(1'b0, 1);
        check("pulses", pulses, 1);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0046, WDCS_RESP_OK);
        rd("istat", WDCS_OFF_ISTAT, 32'h0000_0003, WDCS_RESP_OK);
        pulse_reset(0);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0046, WDCS_RESP_OK);
        pulse_reset(1);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0042, WDCS_RESP_OK);
        $display("test watchdog_reset done");
    endtask : t_watchdog_reset

    task automatic t_restart();
        tick(1'b0, WRAP + 100);
        wr(WDCS_OFF_CTRL, 32'h0000_0043, WDCS_RESP_OK);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0042, WDCS_RESP_OK);
        tick(1'b0, WRAP + DLY - 8);
        check("pulses", pulses, 1);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_004A, WDCS_RESP_OK);
        pulse_reset(1);
        $display("test restart done");
    endtask : t_restart

    task automatic t_clock_select();
        wr(WDCS_OFF_CTRL, 32'h0000_0050, WDCS_RESP_OK);
        tick(1'b0, WRAP + 4);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0050, WDCS_RESP_OK);
        tick(1'b1, WRAP);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0058, WDCS_RESP_OK);
        $display("test clock_select done");
    endtask : t_clock_select

    task automatic t_power_on();
        wr(WDCS_OFF_CTRL, 32'h0000_0002, WDCS_RESP_OK);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0002, WDCS_RESP_OK);
        pulse_reset(2);
        rd("ctrl", WDCS_OFF_CTRL, 32'h0000_0040, WDCS_RESP_OK);
        $display("test power_on done");
    endtask : t_power_on

    // ****************************************
    // Main sequence and hang limit
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_priority();
        t_timeout_irq();
        t_watchdog_reset();
        t_restart();
        t_clock_select();
        t_power_on();
        close_out();
    end

    // Whole run is a few thousand cycles; this only catches a stall
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("BAD run_length expected end seen limit");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
